// *** common/can_rx_filter_pkg.sv ***
// Register map, field positions and reset values of the receive acceptance filter
package can_rx_filter_pkg;
    localparam int ADR_W    = 8;
    localparam int ID_W     = 29;
    localparam int DLC_W    = 4;
    localparam int DATA_W   = 64;
    localparam int NUM_FILT = 6;

    // Byte offsets on the register bus
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] STAT_OFS  = 8'h04;
    localparam logic [7:0] IMASK_OFS = 8'h08;
    localparam logic [7:0] HIT_OFS   = 8'h0c;
    localparam logic [7:0] MASK0_OFS = 8'h10;
    localparam logic [7:0] MASK1_OFS = 8'h14;
    localparam logic [7:0] FILT0_OFS = 8'h18;
    localparam logic [7:0] FILT_END  = 8'h30;
    localparam logic [7:0] RX_BUFFER_ZERO_OFS  = 8'h30;
    localparam logic [7:0] RXB_END   = 8'h50;

    // Control register
    localparam int CTRL_DOUBLE_BUFFER_ENABLE = 0;

    // Status and interrupt mask layout
    localparam int ST_W    = 5;
    localparam int ST_RX0  = 0;
    localparam int ST_RX1  = 1;
    localparam int ST_OVR0 = 2;
    localparam int ST_OVR1 = 3;
    localparam int ST_ERR  = 4;

    // Filter-hit register layout
    localparam int HIT0_BIT = 0;
    localparam int HIT1_LSB = 4;

    // Filter and mask word: id in [28:0], type bit in [31]
    localparam int TYPE_BIT = 31;
    localparam logic [31:0] FM_RW_MASK = 32'h9fff_ffff;
    localparam logic [ID_W-1:0] STD_ID_BITS = 29'h1ffc_0000;
    localparam logic [ID_W-1:0] EXT_ID_BITS = 29'h1fff_ffff;

    // Buffer identifier word: rtr in [29], ide in [30]
    localparam int BUF_RTR_BIT = 29;
    localparam int BUF_IDE_BIT = 30;

    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [2:0]  HIT1_RST = 3'h0;
endpackage : can_rx_filter_pkg

// *** src/can_rx_acceptance_filter.sv ***
// Acceptance filtering and receive buffer steering with a Wishbone register slave
//
// Contract
// - A cleared mask bit makes that identifier bit match regardless of values.
// - A set mask bit matches only when filter and received bits are equal.
// - Load a valid assembled frame only when some filter matches all examined bits.
// - Received extension bit set means extended frame, clear means standard frame.
// - Type mask set: filter takes only the frame type given by its select bit.
// - Type mask clear: filter takes both frame types when identifier bits match.
// - Filters 0-1 use mask 0 to buffer 0; filters 2-5 use mask 1 to buffer 1.
// - Loading buffer 0 records which of filter 0 or 1 hit in one bit.
// - Loading buffer 1 writes code 2..5, or 0/1 when diverted by double buffering.
// - Several matching filters report the lowest-numbered one.
// - Frame for an unreleased buffer, unless double buffering diverts it, sets its overrun and error flags, is discarded.
// - Overrun never stalls the engine; frames for a full buffer are dropped unless double buffering diverts them.
// - Double buffering off: frame for full buffer 0 sets buffer 0 overrun only.
// - Double buffering on: buffer 0 full, buffer 1 empty diverts into buffer 1.
// - Double buffering on, both full: discard and set buffer 1 overrun.
// - Frame matching both groups prefers buffer 0; full without diversion overruns it.
// - Receive flag set only on load; software clears it to release the buffer.
`timescale 1ns/1ps
module can_rx_acceptance_filter
    import can_rx_filter_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              sys_rst_i,
    // Wishbone classic slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Assembly buffer from the protocol engine
    input  wire logic              frame_valid_i,
    input  wire logic [ID_W-1:0]   frame_id_i,
    input  wire logic              received_id_extension_i,
    input  wire logic              frame_rtr_i,
    input  wire logic [DLC_W-1:0]  frame_dlc_i,
    input  wire logic [DATA_W-1:0] frame_data_i,
    output logic                   irq_o
);

    // Register map, byte offsets, all words 32 bits, reserved bits read 0:
    //   00 control: bit 0 enables double buffering
    //   04 status, write one to clear: rx0 full, rx1 full, ovr0, ovr1, error
    //   08 interrupt mask, same layout as status
    //   0c filter hit: bit 0 for buffer 0, bits 6:4 code for buffer 1
    //   10, 14 masks 0 and 1: id bits 28:0, type enable in bit 31
    //   18 to 2c filters 0 to 5: id bits 28:0, extended select in bit 31
    //   30 to 3c buffer 0: id word, length, data low, data high
    //   40 to 4c buffer 1, same layout
    // A full flag is the receive flag; clearing it is what releases the buffer,
    // so software must read the buffer before writing the clear.

    // Register state
    logic [31:0]       filt_reg [NUM_FILT];
    logic [31:0]       mask_reg [2];
    logic              double_buffer_enable;
    logic [ST_W-1:0]   status;
    logic [ST_W-1:0]   irq_mask;
    logic              filter_hit_zero;
    logic [2:0]        filter_hit_code;

    // Receive buffers
    logic [ID_W-1:0]   buf_id   [2];
    logic              buf_ide  [2];
    logic              buf_rtr  [2];
    logic [DLC_W-1:0]  buf_dlc  [2];
    logic [DATA_W-1:0] buf_data [2];

    // Bus decode
    wire logic [7:0]  adr_w   = {wb_adr_i[7:2], 2'b00};
    wire logic        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire logic        wr_en   = req & wb_we_i;
    wire logic [31:0] wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                                 {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    wire logic [31:0] wdat    = wb_dat_i & wmask;
    wire logic        sel_ctl = (adr_w == CTRL_OFS);
    wire logic        sel_st  = (adr_w == STAT_OFS);
    wire logic        sel_im  = (adr_w == IMASK_OFS);
    wire logic        sel_hit = (adr_w == HIT_OFS);
    wire logic        sel_m0  = (adr_w == MASK0_OFS);
    wire logic        sel_m1  = (adr_w == MASK1_OFS);
    wire logic        sel_flt = (adr_w >= FILT0_OFS) && (adr_w < FILT_END);
    wire logic        sel_buf = (adr_w >= RX_BUFFER_ZERO_OFS) && (adr_w < RXB_END);
    wire logic [7:0]  flt_off = adr_w - FILT0_OFS;
    wire logic [7:0]  buf_off = adr_w - RX_BUFFER_ZERO_OFS;
    wire logic [2:0]  flt_idx = flt_off[4:2];
    wire logic        buf_idx = buf_off[4];
    wire logic [1:0]  buf_wrd = buf_off[3:2];

    // Acceptance match, one comparator per filter
    logic [NUM_FILT-1:0] match;
    wire logic [ID_W-1:0] examined =
        received_id_extension_i ? EXT_ID_BITS : STD_ID_BITS;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_FILT; gi++) begin : g_filt
            localparam int MI = (gi < 2) ? 0 : 1;
            wire logic [ID_W-1:0] diff =
                mask_reg[MI][ID_W-1:0] & examined &
                (filt_reg[gi][ID_W-1:0] ^ frame_id_i);
            wire logic type_ok = ~mask_reg[MI][TYPE_BIT] |
                (filt_reg[gi][TYPE_BIT] == received_id_extension_i);
            assign match[gi] = (diff == '0) & type_ok;

            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    filt_reg[gi] <= REG_RST;
                end else if (wr_en && sel_flt && flt_idx == 3'(gi)) begin
                    filt_reg[gi] <= ((filt_reg[gi] & ~wmask) | wdat) & FM_RW_MASK;
                end
            end
        end
    endgenerate

    // Steering decision
    wire logic full0  = status[ST_RX0];
    wire logic full1  = status[ST_RX1];
    wire logic hit_g0 = |match[1:0];
    wire logic hit_g1 = |match[NUM_FILT-1:2];
    wire logic g0_sel = ~match[0];
    wire logic [2:0] g1_code = match[2] ? 3'h2 :
                               match[3] ? 3'h3 :
                               match[4] ? 3'h4 : 3'h5;
    wire logic go_g0  = frame_valid_i & hit_g0;
    wire logic go_g1  = frame_valid_i & ~hit_g0 & hit_g1;
    wire logic divert = go_g0 & full0 & double_buffer_enable;
    wire logic load0  = go_g0 & ~full0;
    wire logic load1  = (divert & ~full1) | (go_g1 & ~full1);
    wire logic ovr0   = go_g0 & full0 & ~double_buffer_enable;
    wire logic ovr1   = (divert & full1) | (go_g1 & full1);
    wire logic [2:0] code1 = go_g0 ? {2'b00, g0_sel} : g1_code;

    // Status: hardware set wins over a write-one clear in the same cycle
    wire logic [ST_W-1:0] st_set;
    assign st_set[ST_RX0]  = load0;
    assign st_set[ST_RX1]  = load1;
    assign st_set[ST_OVR0] = ovr0;
    assign st_set[ST_OVR1] = ovr1;
    assign st_set[ST_ERR]  = ovr0 | ovr1;
    wire logic [ST_W-1:0] st_clr = (wr_en && sel_st) ? wdat[ST_W-1:0] : '0;
    wire logic [ST_W-1:0] next_status = (status & ~st_clr) | st_set;
    // Mask seen by the interrupt flop, so a mask write acts at once instead of a cycle late
    wire logic            im_wr = wr_en & sel_im & wb_sel_i[0];
    wire logic [ST_W-1:0] next_irq_mask = im_wr ? wb_dat_i[ST_W-1:0] : irq_mask;

    // Read mux
    wire logic [31:0] filt_rd = filt_reg[flt_idx];
    wire logic [31:0] buf_w0  = {1'b0, buf_ide[buf_idx], buf_rtr[buf_idx],
                                 buf_id[buf_idx]};
    wire logic [31:0] buf_rd  =
        (buf_wrd == 2'd0) ? buf_w0 :
        (buf_wrd == 2'd1) ? {{(32-DLC_W){1'b0}}, buf_dlc[buf_idx]} :
        (buf_wrd == 2'd2) ? buf_data[buf_idx][31:0] :
                            buf_data[buf_idx][63:32];
    wire logic [31:0] hit_rd  = (32'(filter_hit_code) << HIT1_LSB) |
                                (32'(filter_hit_zero) << HIT0_BIT);
    wire logic [31:0] rd_word =
        sel_ctl ? (32'(double_buffer_enable) << CTRL_DOUBLE_BUFFER_ENABLE) :
        sel_st  ? 32'(status) :
        sel_im  ? 32'(irq_mask) :
        sel_hit ? hit_rd :
        sel_m0  ? mask_reg[0] :
        sel_m1  ? mask_reg[1] :
        sel_flt ? filt_rd :
        sel_buf ? buf_rd : REG_RST;   // Unmapped reads return zero and still ack

    // Bus slave: one wait state, ack for exactly one cycle
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= REG_RST;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_word : REG_RST;
        end
    end

    // Software-written configuration
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            double_buffer_enable <= 1'b0;
            irq_mask             <= '0;
            mask_reg[0]          <= REG_RST;
            mask_reg[1]          <= REG_RST;
        end else if (wr_en) begin
            if (sel_ctl && wb_sel_i[0]) begin
                double_buffer_enable <= wb_dat_i[CTRL_DOUBLE_BUFFER_ENABLE];
            end
            if (sel_im && wb_sel_i[0]) begin
                irq_mask <= wb_dat_i[ST_W-1:0];
            end
            if (sel_m0) begin
                mask_reg[0] <= ((mask_reg[0] & ~wmask) | wdat) & FM_RW_MASK;
            end
            if (sel_m1) begin
                mask_reg[1] <= ((mask_reg[1] & ~wmask) | wdat) & FM_RW_MASK;
            end
        end
    end

    // Flags and interrupt; the engine is never stalled by an overrun
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            status <= '0;
            irq_o  <= 1'b0;
        end else begin
            status <= next_status;
            irq_o  <= |(next_status & next_irq_mask);
        end
    end

    // Filter-hit codes change only when a buffer is loaded
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            filter_hit_zero <= 1'b0;
            filter_hit_code <= HIT1_RST;
        end else begin
            if (load0) begin
                filter_hit_zero <= g0_sel;
            end
            if (load1) begin
                filter_hit_code <= code1;
            end
        end
    end

    // Buffer contents; a discarded frame writes nothing
    generate
        for (gi = 0; gi < 2; gi++) begin : g_buf
            wire logic ld = (gi == 0) ? load0 : load1;
            always_ff @(posedge clk_i or posedge sys_rst_i) begin
                if (sys_rst_i) begin
                    buf_id[gi]   <= '0;
                    buf_ide[gi]  <= 1'b0;
                    buf_rtr[gi]  <= 1'b0;
                    buf_dlc[gi]  <= '0;
                    buf_data[gi] <= '0;
                end else if (ld) begin
                    buf_id[gi]   <= frame_id_i;
                    buf_ide[gi]  <= received_id_extension_i;
                    buf_rtr[gi]  <= frame_rtr_i;
                    buf_dlc[gi]  <= frame_dlc_i;
                    buf_data[gi] <= frame_data_i;
                end
            end
        end
    endgenerate

endmodule : can_rx_acceptance_filter

// *** test/can_frame_source.sv ***
// Protocol engine stand-in presenting assembled frames
`timescale 1ns/1ps
module can_frame_source
    import can_rx_filter_pkg::*;
(
    input  wire logic              clk_i,
    output logic                   frame_valid_o = 1'b0,
    output logic [ID_W-1:0]        frame_id_o = '0,
    output logic                   ide_o = 1'b0,
    output logic                   rtr_o = 1'b0,
    output logic [DLC_W-1:0]       dlc_o = 4'h8,
    output logic [DATA_W-1:0]      data_o = '0
);
    // Identifier, extension and data fields are inverted after the pulse so a stale sample can never match
    task automatic send(input logic [ID_W-1:0] id, input logic ext);
        @(posedge clk_i);
        frame_valid_o <= 1'b1;
        frame_id_o    <= id;
        ide_o         <= ext;
        data_o        <= {~{3'h0, id}, {3'h0, id}};
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
        frame_id_o    <= ~id;
        ide_o         <= ~ext;
        data_o        <= ~data_o;
    endtask : send
endmodule : can_frame_source

// *** test/can_rx_acceptance_filter_assertions.sv ***
// Port-level checker for the receive acceptance filter
`timescale 1ns/1ps
module can_rx_acceptance_filter_assertions
    import can_rx_filter_pkg::*;
(
    input wire logic             clk_i,
    input wire logic             sys_rst_i,
    input wire logic             wb_cyc_i,
    input wire logic             wb_stb_i,
    input wire logic             wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [31:0]      wb_dat_o,
    input wire logic             wb_ack_o,
    input wire logic             frame_valid_i,
    input wire logic             irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire logic rd  = wb_ack_o && !wb_we_i;
    sequence s_take; req; endsequence
    sequence s_answer; wb_ack_o ##1 !wb_ack_o; endsequence
    a_ack_one_wait: assert property (s_take |=> s_answer) else $error("ack late or long");
    a_ack_needs_req: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    a_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("dat not 0");
    a_irq_quiet_hold: assert property (
        !frame_valid_i && !(req && wb_we_i) |=> $stable(irq_o))
        else $error("irq moved without cause");
    a_clear_no_rise: assert property (
        req && wb_we_i && wb_adr_i[7:2] == STAT_OFS[7:2]
        && !frame_valid_i |=> !$rose(irq_o)) else $error("status clear raised irq");
    a_hit_code_range: assert property (
        rd && wb_adr_i[7:2] == HIT_OFS[7:2]
        |-> wb_dat_o[6:4] <= 3'h5 && (wb_dat_o & 32'hffff_ff8e) == 32'h0)
        else $error("bad hit code");
    a_filt_reserved: assert property (rd && wb_adr_i >= MASK0_OFS && wb_adr_i < FILT_END
        |-> (wb_dat_o & ~FM_RW_MASK) == 32'h0) else $error("filter reserved bits set");
    a_unmapped_zero: assert property (rd && wb_adr_i >= RXB_END |-> wb_dat_o == 32'h0)
        else $error("unmapped read not 0");
endmodule : can_rx_acceptance_filter_assertions

bind can_rx_acceptance_filter can_rx_acceptance_filter_assertions u_chk (.clk_i(clk_i),
    .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .frame_valid_i(frame_valid_i), .irq_o(irq_o));

// *** test/can_rx_acceptance_filter_tb_top.sv ***
// Register-level tests of filtering, steering and overrun
`timescale 1ns/1ps
module can_rx_acceptance_filter_tb_top
    import can_rx_filter_pkg::*;
;
    logic clk_i, sys_rst_i, cyc, stb, we, fv, ide, rtr, ack, irq;
    logic [ADR_W-1:0] adr;
    logic [3:0] sel;
    logic [31:0] wdat, rdat;
    logic [ID_W-1:0] fid;
    logic [DLC_W-1:0] dlc;
    logic [DATA_W-1:0] fdat;
    int n_errors = 0;
    int samples_checked = 0;
    localparam logic [ID_W-1:0] IA = {11'h123, 18'h0};
    localparam logic [ID_W-1:0] IB = {11'h2a5, 18'h0};
    localparam logic [ID_W-1:0] IC = {11'h055, 18'h0};
    localparam logic [ID_W-1:0] IE = {11'h701, 18'h0};
    localparam logic [31:0] CFG [8] = '{32'h9ffc_0000, 32'h1ffc_0000, {3'h0, IA},
        {3'h0, IB}, {3'h0, IC}, {3'h0, IC}, {3'h0, IA}, {3'h0, IE}};
    can_rx_acceptance_filter u_can_rx_acceptance_filter (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .frame_valid_i(fv),
        .frame_id_i(fid), .received_id_extension_i(ide), .frame_rtr_i(rtr),
        .frame_dlc_i(dlc), .frame_data_i(fdat), .irq_o(irq));
    can_frame_source u_can_frame_source (.clk_i(clk_i), .frame_valid_o(fv), .frame_id_o(fid),
        .ide_o(ide), .rtr_o(rtr), .dlc_o(dlc), .data_o(fdat));
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    task automatic tally_and_finish();
        $display("checks=%0d errors=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_errors++;
        end
    endtask : chk
    // Request held until ack is sampled high; data taken at that same edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        @(posedge clk_i);
        while (ack !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 50) begin
            n_errors++;
            tally_and_finish();
        end
        q = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask : rc
    initial begin
        #50us;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        {cyc, stb, we, adr, wdat, sel} = {3'b000, 8'h0, 32'h0, 4'hf};
        sys_rst_i = 1'b1;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rc(STAT_OFS, 32'h0);
        rc(HIT_OFS, 32'h0);
        for (int i = 0; i < 8; i++) wr(MASK0_OFS + 8'(4 * i), CFG[i]);
        wr(IMASK_OFS, 32'h1f);
        u_can_frame_source.send(IA ^ {11'h001, 18'h0}, 1'b0);
        rc(STAT_OFS, 32'h0);
        u_can_frame_source.send(IA | 29'h3ffff, 1'b0);
        rc(STAT_OFS, 32'h1);
        rc(RX_BUFFER_ZERO_OFS, {3'h0, IA | 29'h3ffff});
        rc(RX_BUFFER_ZERO_OFS + 8'h8, {3'h0, IA | 29'h3ffff});
        rc(RX_BUFFER_ZERO_OFS + 8'h4, 32'h8);
        rc(RX_BUFFER_ZERO_OFS + 8'hc, ~{3'h0, IA | 29'h3ffff});
        u_can_frame_source.send(IB, 1'b1);
        rc(STAT_OFS, 32'h1);
        u_can_frame_source.send(IB, 1'b0);
        rc(STAT_OFS, 32'h15);
        chk({31'h0, irq}, 32'h1);
        u_can_frame_source.send(IC, 1'b1);
        rc(STAT_OFS, 32'h17);
        rc(HIT_OFS, 32'h20);
        u_can_frame_source.send(IE, 1'b0);
        rc(STAT_OFS, 32'h1f);
        rc(RX_BUFFER_ZERO_OFS + 8'h10, {3'h2, IC});
        wr(IMASK_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(IMASK_OFS, 32'h1f);
        wr(STAT_OFS, 32'h1f);
        rc(STAT_OFS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr(CTRL_OFS, 32'h1);
        rc(CTRL_OFS, 32'h1);
        u_can_frame_source.send(IB, 1'b0);
        u_can_frame_source.send(IA, 1'b0);
        rc(STAT_OFS, 32'h3);
        rc(HIT_OFS, 32'h01);
        u_can_frame_source.send(IA, 1'b0);
        rc(STAT_OFS, 32'h1b);
        wr(8'h60, 32'hffff_ffff);
        rc(8'h60, 32'h0);
        tally_and_finish();
    end
endmodule : can_rx_acceptance_filter_tb_top
